// ==== rtl/npirw_regs.svh ====
`ifndef NPIRW_REGS_SVH
`define NPIRW_REGS_SVH

// Register byte offsets
`define NPIRW_OFS_DIR    8'h00
`define NPIRW_OFS_OUT    8'h04
`define NPIRW_OFS_IN     8'h08
`define NPIRW_OFS_MODE   8'h0C
`define NPIRW_OFS_PWMEN  8'h10
`define NPIRW_OFS_DUTY0  8'h14
`define NPIRW_OFS_DUTY1  8'h18
`define NPIRW_OFS_DUTY2  8'h1C
`define NPIRW_OFS_DUTY3  8'h20
`define NPIRW_OFS_POWER  8'h24

// Field positions
`define NPIRW_MODE_IR_SEL 1
`define NPIRW_MODE_IR_EN  3
`define NPIRW_PWR_HALT    0
`define NPIRW_PWR_WAKE    1
`define NPIRW_B3          7
`define NPIRW_C0          8
`define NPIRW_C3          11

// Reset values
`define NPIRW_RST_16     16'h0000
`define NPIRW_RST_DUTY   8'h00
`define NPIRW_RST_PWMEN  4'h0

// AXI answers
`define NPIRW_RESP_OKAY   2'h0
`define NPIRW_RESP_SLVERR 2'h2

// Timing
`define NPIRW_CLK_HZ     100000000
`define NPIRW_IR_HZ      38500
`define NPIRW_IR_HALF    (`NPIRW_CLK_HZ / (2 * `NPIRW_IR_HZ))
`define NPIRW_PWM_TOP    8'hFF

`endif

// ==== rtl/npirw_pkg.sv ====
package npirw_pkg;

  typedef enum logic [1:0] {
    NPIRW_RUN  = 2'b00,
    NPIRW_STOP = 2'b01
  } npirw_pwr_e;

  typedef struct packed {
    logic ir_en;
    logic ir_sel;
  } npirw_mode_s;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pull;
  } npirw_pad_s;

endpackage

// ==== rtl/npirw_pwm.sv ====
`timescale 1ns/100ps
`include "npirw_regs.svh"

module npirw_pwm
  import npirw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Duty and output
  input  wire logic [7:0] duty,
  output logic            pwm
);

  logic [7:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm <= 1'b0;
    end else begin
      pwm <= (cnt < duty);
    end
  end

  pwm_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt == `NPIRW_PWM_TOP |=> cnt == 8'h00)
    else $error("pwm counter did not wrap");

  pwm_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwm == ($past(cnt) < $past(duty)))
    else $error("pwm level does not follow duty");

endmodule

// ==== rtl/npirw_top.sv ====
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "npirw_regs.svh"

// Operation
// - Sixteen pins, each input pull-low or output
// - Halt stops clock, pins hold state
// - Any pin edge while stopped wakes
// - Mode bit 3 enables infrared carrier
// - Port C bit 3 gated by carrier
// - Select bit routes to B3 or C3
// - Four port C pins, own duty each
module npirw_top
  import npirw_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Pins: [3:0] A, [7:4] B, [11:8] C, [15:12] D
  input  wire logic [15:0] PORT_IN,
  output logic [15:0]      PORT_OUT,
  output logic [15:0]      PORT_OE,
  output logic [15:0]      PORT_PULL,
  // System clock gate
  output logic             CLK_RUN
);

  localparam logic [10:0] IR_HALF = 11'(`NPIRW_IR_HALF);

  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [15:0] dir;
  logic [15:0] out_reg;
  npirw_mode_s mode;
  logic [3:0]  pwm_en;
  logic [7:0]  duty [4];
  logic [3:0]  pwm;
  npirw_pwr_e  pwr;
  logic        wake_flag;
  logic [15:0] in_prev;
  logic        pin_edge;
  logic        halt_req;
  logic [10:0] car_cnt;
  logic        carrier;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;
  npirw_pad_s  next_pad;

  assign do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign halt_req = do_write && aw_addr == `NPIRW_OFS_POWER && w_strb[0]
                    && w_data[`NPIRW_PWR_HALT];
  assign pin_edge = |(PORT_IN ^ in_prev);

  // Write channels, either order
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `NPIRW_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_addr       <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `NPIRW_RESP_OKAY : `NPIRW_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_comb begin
    case (aw_addr)
      `NPIRW_OFS_DIR, `NPIRW_OFS_OUT, `NPIRW_OFS_IN, `NPIRW_OFS_MODE,
      `NPIRW_OFS_PWMEN, `NPIRW_OFS_DUTY0, `NPIRW_OFS_DUTY1,
      `NPIRW_OFS_DUTY2, `NPIRW_OFS_DUTY3, `NPIRW_OFS_POWER: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir     <= `NPIRW_RST_16;
      out_reg <= `NPIRW_RST_16;
    end else if (do_write) begin
      if (aw_addr == `NPIRW_OFS_DIR) begin
        if (w_strb[0]) dir[7:0] <= w_data[7:0];
        if (w_strb[1]) dir[15:8] <= w_data[15:8];
      end
      if (aw_addr == `NPIRW_OFS_OUT) begin
        if (w_strb[0]) out_reg[7:0] <= w_data[7:0];
        if (w_strb[1]) out_reg[15:8] <= w_data[15:8];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode   <= '0;
      pwm_en <= `NPIRW_RST_PWMEN;
      for (int i = 0; i < 4; i++) begin
        duty[i] <= `NPIRW_RST_DUTY;
      end
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == `NPIRW_OFS_MODE) begin
        mode.ir_en  <= w_data[`NPIRW_MODE_IR_EN];
        mode.ir_sel <= w_data[`NPIRW_MODE_IR_SEL];
      end
      if (aw_addr == `NPIRW_OFS_PWMEN) pwm_en <= w_data[3:0];
      if (aw_addr == `NPIRW_OFS_DUTY0) duty[0] <= w_data[7:0];
      if (aw_addr == `NPIRW_OFS_DUTY1) duty[1] <= w_data[7:0];
      if (aw_addr == `NPIRW_OFS_DUTY2) duty[2] <= w_data[7:0];
      if (aw_addr == `NPIRW_OFS_DUTY3) duty[3] <= w_data[7:0];
    end
  end

  // Read channel
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (S_AXI_ARADDR)
      `NPIRW_OFS_DIR:   rd_data[15:0] = dir;
      `NPIRW_OFS_OUT:   rd_data[15:0] = out_reg;
      `NPIRW_OFS_IN:    rd_data[15:0] = PORT_IN;
      `NPIRW_OFS_MODE: begin
        rd_data[`NPIRW_MODE_IR_EN]  = mode.ir_en;
        rd_data[`NPIRW_MODE_IR_SEL] = mode.ir_sel;
      end
      `NPIRW_OFS_PWMEN: rd_data[3:0] = pwm_en;
      `NPIRW_OFS_DUTY0: rd_data[7:0] = duty[0];
      `NPIRW_OFS_DUTY1: rd_data[7:0] = duty[1];
      `NPIRW_OFS_DUTY2: rd_data[7:0] = duty[2];
      `NPIRW_OFS_DUTY3: rd_data[7:0] = duty[3];
      `NPIRW_OFS_POWER: begin
        rd_data[`NPIRW_PWR_HALT] = (pwr == NPIRW_STOP);
        rd_data[`NPIRW_PWR_WAKE] = wake_flag;
      end
      default:          rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `NPIRW_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_data;
      S_AXI_RRESP   <= rd_ok ? `NPIRW_RESP_OKAY : `NPIRW_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwr     <= NPIRW_RUN;
      CLK_RUN <= 1'b1;
      in_prev <= `NPIRW_RST_16;
    end else begin
      in_prev <= PORT_IN;
      case (pwr)
        NPIRW_RUN: begin
          if (halt_req) begin
            pwr     <= NPIRW_STOP;
            CLK_RUN <= 1'b0;
          end
        end
        NPIRW_STOP: begin
          if (pin_edge) begin
            pwr     <= NPIRW_RUN;
            CLK_RUN <= 1'b1;
          end
        end
        default: begin
          pwr     <= NPIRW_RUN;
          CLK_RUN <= 1'b1;
        end
      endcase
    end
  end

  // Sticky wake flag; a new wake beats a clear
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wake_flag <= 1'b0;
    end else if (pwr == NPIRW_STOP && pin_edge) begin
      wake_flag <= 1'b1;
    end else if (do_write && aw_addr == `NPIRW_OFS_POWER && w_strb[0]
                 && w_data[`NPIRW_PWR_WAKE]) begin
      wake_flag <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      car_cnt <= 11'h000;
      carrier <= 1'b0;
    end else if (car_cnt == IR_HALF - 11'h001) begin
      car_cnt <= 11'h000;
      carrier <= ~carrier;
    end else begin
      car_cnt <= car_cnt + 11'h001;
    end
  end

  // one channel per port C pin
  for (genvar g = 0; g < 4; g++) begin : g_pwm
    npirw_pwm u_pwm (
      .clk   (SYS_CLK),
      .rst_n (RESETN),
      .duty  (duty[g]),
      .pwm   (pwm[g])
    );
  end

  always_comb begin
    next_pad.out  = out_reg;
    next_pad.oe   = dir;
    next_pad.pull = ~dir;
    for (int i = 0; i < 4; i++) begin
      if (pwm_en[i]) next_pad.out[`NPIRW_C0 + i] = pwm[i];
    end
    if (mode.ir_en && mode.ir_sel) begin
      next_pad.out[`NPIRW_B3] = out_reg[`NPIRW_C3] & carrier;
    end
    if (mode.ir_en && !mode.ir_sel) begin
      next_pad.out[`NPIRW_C3] = out_reg[`NPIRW_C3] & carrier;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PORT_OUT  <= `NPIRW_RST_16;
      PORT_OE   <= `NPIRW_RST_16;
      PORT_PULL <= ~`NPIRW_RST_16;
    end else if (pwr == NPIRW_RUN) begin
      PORT_OUT  <= next_pad.out;
      PORT_OE   <= next_pad.oe;
      PORT_PULL <= next_pad.pull;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  sequence halt_seq;
    pwr == NPIRW_RUN && halt_req;
  endsequence

  stop_gate_a: assert property (halt_seq |=> !CLK_RUN && pwr == NPIRW_STOP)
    else $error("halt did not stop clock");

  stop_hold_a: assert property (pwr == NPIRW_STOP |=> $stable(PORT_OUT) && $stable(PORT_OE))
    else $error("pads changed while stopped");

  wake_edge_a: assert property (pwr == NPIRW_STOP && pin_edge |=> CLK_RUN ##1 $past(CLK_RUN))
    else $error("pin edge did not wake");

  stay_stop_a: assert property (pwr == NPIRW_STOP && !pin_edge |=> !CLK_RUN)
    else $error("woke without pin edge");

  dir_oe_a: assert property (pwr == NPIRW_RUN |=> PORT_OE == $past(dir) && PORT_PULL == ~$past(dir))
    else $error("direction not applied");

  carrier_period_a: assert property (car_cnt == IR_HALF - 11'h001 |=> $changed(carrier))
    else $error("carrier did not toggle at half period");

  ir_c3_a: assert property (pwr == NPIRW_RUN && mode.ir_en && !mode.ir_sel
    |=> PORT_OUT[`NPIRW_C3] == ($past(out_reg[`NPIRW_C3]) & $past(carrier)))
    else $error("port C bit 3 not modulated");

  ir_b3_a: assert property (pwr == NPIRW_RUN && mode.ir_en && mode.ir_sel
    |=> PORT_OUT[`NPIRW_B3] == ($past(out_reg[`NPIRW_C3]) & $past(carrier)))
    else $error("port B bit 3 not modulated");

  ir_off_a: assert property (pwr == NPIRW_RUN && !mode.ir_en && !pwm_en[3]
    |=> PORT_OUT[`NPIRW_C3] == $past(out_reg[`NPIRW_C3]))
    else $error("port C bit 3 changed with infrared off");

  pwm_pin_a: assert property (pwr == NPIRW_RUN && pwm_en[0]
    |=> PORT_OUT[`NPIRW_C0] == $past(pwm[0]))
    else $error("pwm not on port C bit 0");

endmodule

// ==== verif/npirw_pad_model.sv ====
`timescale 1ns/100ps

// Keys, LEDs and emitter hanging on the sixteen pads
module npirw_pad_model
  import npirw_pkg::*;
(
  // From the block
  input  wire npirw_pad_s  pad,
  // Keys held by the bench
  input  wire logic [15:0] key_val,
  input  wire logic [15:0] key_en,
  // Level on each pad
  output logic [15:0]      lvl
);
  // driven or pulled low
  // Pull is always on for inputs, so no pad floats
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad.oe[i])
        lvl[i] = pad.out[i];
      else if (key_en[i])
        lvl[i] = key_val[i];
      else
        lvl[i] = 1'b0;
    end
  end
endmodule

// ==== verif/nibble_port_ir_pwm_wake_tb.sv ====
`timescale 1ns/100ps
`include "npirw_regs.svh"

module nibble_port_ir_pwm_wake_tb;
  logic                   clk, rstn;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic                   awv, awr, wv, wr, bv, bready, arv, arr, rv, rready;
  logic [1:0]             bresp, rresp;
  logic [15:0]            p_in, p_out, p_oe, p_pull, key_val, key_en;
  logic                   clk_run;
  npirw_pkg::npirw_pad_s  pad;
  int                     failures = 0;
  int                     checked = 0;
  int                     cyc = 0;
  logic [1:0]             last_bresp;
  int                     half = `NPIRW_CLK_HZ / (2 * `NPIRW_IR_HZ);

  assign pad = '{out: p_out, oe: p_oe, pull: p_pull};

  npirw_top i_dut (
    .SYS_CLK(clk), .RESETN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .PORT_IN(p_in), .PORT_OUT(p_out), .PORT_OE(p_oe), .PORT_PULL(p_pull),
    .CLK_RUN(clk_run)
  );

  npirw_pad_model i_pads (.pad(pad), .key_val(key_val), .key_en(key_en), .lvl(p_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      give_verdict;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awv && awr === 1'b1) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr === 1'b1) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Edges seen high in the next high run of one pad
  task automatic runlen(input int b, output int n);
    n = 0;
    while (p_out[b] !== 1'b0) @(posedge clk);
    while (p_out[b] !== 1'b1) @(posedge clk);
    while (p_out[b] === 1'b1 && n < 4000) begin
      n++;
      @(posedge clk);
    end
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk("oe", 0, p_oe);
    chk("pull", 16'hFFFF, p_pull);
    chk("clk_run", 1, clk_run);
    axr(`NPIRW_OFS_DIR, d, r);
    chk("dir", 0, d);
  endtask

  task automatic t_ports;
    logic [31:0] d;
    logic [1:0]  r;
    axw(`NPIRW_OFS_DIR, 32'h0FF0);
    axw(`NPIRW_OFS_OUT, 32'h05A0);
    chk("out_bresp", `NPIRW_RESP_OKAY, last_bresp);
    repeat (4) @(posedge clk);
    chk("oe", 16'h0FF0, p_oe);
    chk("pull", 16'hF00F, p_pull);
    chk("out", 16'h05A0, p_out & p_oe);
    axr(`NPIRW_OFS_IN, d, r);
    chk("in", 16'h05A3, d);
    chk("in_resp", `NPIRW_RESP_OKAY, r);
    axr(8'h40, d, r);
    chk("hole_data", 0, d);
    chk("hole_resp", `NPIRW_RESP_SLVERR, r);
    axw(8'h40, 32'hFFFF);
    chk("hole_bresp", `NPIRW_RESP_SLVERR, last_bresp);
    axr(`NPIRW_OFS_DIR, d, r);
    chk("dir_kept", 16'h0FF0, d);
  endtask

  task automatic t_pwm;
    int n[4];
    for (int i = 0; i < 4; i++) begin
      n[i] = 0;
      axw(`NPIRW_OFS_DUTY0 + 8'(4 * i), 32'(i == 3 ? 8'hFF : 8'(8'h40 * i)));
    end
    axw(`NPIRW_OFS_PWMEN, 32'h0000000F);
    repeat (4) @(posedge clk);
    repeat (256) begin
      @(posedge clk);
      for (int i = 0; i < 4; i++)
        n[i] += int'(p_out[8 + i] === 1'b1);
    end
    chk("pwm0", 0, n[0]);
    chk("pwm1", 64, n[1]);
    chk("pwm2", 128, n[2]);
    chk("pwm3", 255, n[3]);
    axw(`NPIRW_OFS_PWMEN, 32'h0);
  endtask

  task automatic t_ir;
    int n;
    axw(`NPIRW_OFS_OUT, 32'h0DA0);
    axw(`NPIRW_OFS_MODE, 32'h8);
    runlen(11, n);
    chk("ir_c3", half, n);
    axw(`NPIRW_OFS_MODE, 32'hA);
    runlen(7, n);
    chk("ir_b3", half, n);
    chk("c3_plain", 1, p_out[11]);
    axw(`NPIRW_OFS_MODE, 32'h0);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (3000) begin
      @(posedge clk);
      n += int'(p_out[11] === 1'b1);
    end
    chk("ir_off", 3000, n);
  endtask

  task automatic t_wake;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    axw(`NPIRW_OFS_POWER, 32'h1);
    repeat (20) @(posedge clk);
    chk("stopped", 0, clk_run);
    chk("oe_held", 16'h0FF0, p_oe);
    key_val[12] <= 1'b1;
    n = 0;
    while (clk_run !== 1'b1 && n < 5) begin
      @(posedge clk);
      n++;
    end
    chk("woken", 1, clk_run);
    axr(`NPIRW_OFS_POWER, d, r);
    chk("wake_flag", 2, d);
    axw(`NPIRW_OFS_POWER, 32'h2);
    axr(`NPIRW_OFS_POWER, d, r);
    chk("wake_clr", 0, d);
  endtask

  initial begin
    rstn = 1'b0;
    {awaddr, araddr, wdata, awv, wv, bready, arv, rready} = '0;
    wstrb = 4'hF;
    key_en = 16'hF00F;
    key_val = 16'h0003;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_ports;
    t_pwm;
    t_ir;
    t_wake;
    give_verdict;
  end
endmodule
